// File: hw/lec_cell_reg.sv
// Programmable storage element of one logic cell
`timescale 1ns/1ps

module lec_cell_reg (
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Configuration
  input lec_pkg::lec_ff_e ff,
  input lec_pkg::lec_amode_e amode,
  // Data and controls
  input logic v,
  input logic aux,
  input logic ld_data,
  input logic tick,
  input logic ctl_a_n,
  input logic ctl_b_n,
  // Stored value
  output logic q
);

  logic clr_n; // Effective clear, low active
  logic pre_n; // Effective preset, low active
  logic ld; // Load request from line A
  logic next_q; // Value taken on a clock tick

  // Map the two lines onto clear and preset
  always_comb begin
    ld = ~ctl_a_n;
    clr_n = 1'b1;
    pre_n = 1'b1;
    unique case (amode)
      lec_pkg::LEC_AS_NONE: begin
        clr_n = 1'b1;
      end
      lec_pkg::LEC_AS_CLR: begin
        clr_n = ctl_b_n;
      end
      lec_pkg::LEC_AS_PRE: begin
        pre_n = ctl_a_n;
      end
      lec_pkg::LEC_AS_CLR_PRE: begin
        pre_n = ctl_a_n;
        clr_n = ctl_b_n;
      end
      // Load steers preset or clear by the data bit
      lec_pkg::LEC_AS_LD_CLR: begin
        pre_n = ~(ld & ld_data);
        clr_n = ~(ld & ~ld_data) & ctl_b_n;
      end
      lec_pkg::LEC_AS_LD_PRE: begin
        pre_n = ~(ld & ld_data) & ctl_b_n;
        clr_n = ~(ld & ~ld_data);
      end
      lec_pkg::LEC_AS_LD: begin
        pre_n = ~(ld & ld_data);
        clr_n = ~(ld & ~ld_data);
      end
      // Illegal code acts as no clear and no preset
      default: begin
        clr_n = 1'b1;
      end
    endcase
  end

  // Next value by storage kind
  always_comb begin
    unique case (ff)
      lec_pkg::LEC_FF_D: next_q = v;
      lec_pkg::LEC_FF_T: next_q = q ^ v;
      lec_pkg::LEC_FF_JK: next_q = (v & ~q) | (~aux & q);
      lec_pkg::LEC_FF_SR: next_q = v | (~aux & q);
    endcase
  end

  // Clear beats preset, both beat the clock tick
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= 1'b0;
    end else if (!clr_n) begin
      q <= 1'b0;
    end else if (!pre_n) begin
      q <= 1'b1;
    end else if (tick) begin
      q <= next_q;
    end
  end

endmodule // lec_cell_reg

// File: hw/lec_cluster.sv
// Cluster of logic cells with chains, control lines and config port
`timescale 1ns/1ps
`include "lec_map.svh"

module lec_cluster #(
  parameter int CELLS = 8
) (
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Register port
  input lec_pkg::lec_bus_s bus,
  output logic [31:0] rdata,
  // Dedicated and I/O control pins
  input logic [3:0] ded_in,
  input logic [3:0] io_ctl_in,
  // Local interconnect from the fabric
  input logic [3:0] local_ctl,
  input logic [CELLS-1:0][3:0] data_in,
  // Row chains from and to neighbour clusters
  input logic carry_in,
  input logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  // Cell outputs towards the fabric
  output logic [CELLS-1:0] cell_output
);

  // Configuration words, one per cell
  lec_pkg::lec_cell_cfg_s cfg [CELLS];
  // Control line sources
  logic [15:0] ctrl;
  // Read value before the output register
  logic [31:0] rd_val;

  // Pin synchronisers, first and second stage
  logic [3:0] ded_s1;
  logic [3:0] ded_s2;
  logic [3:0] io_s1;
  logic [3:0] io_s2;

  // Selected control lines
  logic [3:0] line;
  // Previous clock line levels for edge finding
  logic [1:0] clk_q;
  // One cycle tick per clock line rise
  logic [1:0] tick;

  // Chain nodes, node 0 from the left neighbour
  logic [CELLS:0] carry;
  logic [CELLS:0] casc;
  // Combinational cell outputs
  logic [CELLS-1:0] out_c;

  // Configuration writes, one word per cell
  for (genvar i = 0; i < CELLS; i++) begin : g_cfg
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        cfg[i] <= `LEC_CFG_RST;
      end else if (bus.wr && bus.addr == 8'(`LEC_CFG_BASE + 4 * i)) begin
        cfg[i] <= bus.wdata;
      end
    end
  end

  // Control source register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `LEC_CTRL_RST;
    end else if (bus.wr && bus.addr == `LEC_CTRL_OFS) begin
      ctrl <= bus.wdata[15:0];
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    for (int i = 0; i < CELLS; i++) begin
      if (bus.addr == 8'(`LEC_CFG_BASE + 4 * i)) begin
        rd_val = cfg[i];
      end
    end
    if (bus.addr == `LEC_CTRL_OFS) begin
      rd_val = {16'h0000, ctrl};
    end else if (bus.addr == `LEC_STAT_OFS) begin
      // Live state of the cluster outputs
      rd_val[CELLS-1:0] = cell_output;
      rd_val[`LEC_STAT_COUT_BIT] = carry_out;
      rd_val[`LEC_STAT_CASC_BIT] = cascade_out;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata <= rd_val;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Two flops on every pin; idle high so clear stays off
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ded_s1 <= 4'hF;
      ded_s2 <= 4'hF;
      io_s1 <= 4'hF;
      io_s2 <= 4'hF;
    end else begin
      ded_s1 <= ded_in;
      ded_s2 <= ded_s1;
      io_s1 <= io_ctl_in;
      io_s2 <= io_s1;
    end
  end

  // Source selection per control line
  for (genvar k = 0; k < 4; k++) begin : g_line
    lec_pkg::lec_src_e src;
    logic [1:0] pin;
    logic sel; // Chosen level, one driver per bit of line
    assign src = lec_pkg::lec_src_e'(
      ctrl[`LEC_LINE_W * k + `LEC_SRC_LSB +: 2]);
    assign pin = ctrl[`LEC_LINE_W * k + `LEC_PIN_LSB +: 2];
    always_comb begin
      unique case (src)
        // Any of the four global dedicated inputs
        lec_pkg::LEC_SRC_DED: sel = ded_s2[pin];
        // The line's own I/O pin
        lec_pkg::LEC_SRC_IO: sel = io_s2[k];
        // Internal logic over local interconnect
        lec_pkg::LEC_SRC_LOCAL: sel = local_ctl[k];
        // Unused line held high
        lec_pkg::LEC_SRC_HIGH: sel = 1'b1;
      endcase
    end
    assign line[k] = sel;
  end

  // Remember clock line levels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clk_q <= 2'b11;
    end else begin
      clk_q <= line[`LEC_CLK1:`LEC_CLK0];
    end
  end

  // A rise on either clock line gives a one cycle tick.
  // Line clocks far below mclk only; a faster one loses edges.
  assign tick = line[`LEC_CLK1:`LEC_CLK0] & ~clk_q;

  // Chain ends joined to the row neighbours
  assign carry[0] = carry_in;
  assign casc[0] = cascade_in;

  // One logic cell per index
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic [3:0] d; // Four data inputs
    logic q; // Stored value, fed back
    logic [3:0] idx4; // Normal mode table index
    logic [2:0] idx3; // Three-input table index
    logic f; // Table result
    logic comb; // Result after cascade
    logic cnt_mux; // Load selector output
    logic v; // Storage data input
    logic cout; // Carry to the next cell
    logic cso; // Cascade to the next cell
    lec_pkg::lec_ff_e ff_eff; // Effective storage kind

    assign d = data_in[i];

    // Table and mode routing of seven inputs
    always_comb begin
      // Carry or fourth data input on the top index bit
      idx4 = {cfg[i].carry_sel ? carry[i] : d[3], d[2:0]};
      idx3 = {carry[i], d[1], d[0]};
      f = 1'b0;
      cout = carry[i];
      cnt_mux = 1'b0;
      comb = 1'b0;
      cso = casc[i];
      v = 1'b0;
      ff_eff = cfg[i].ff;
      unique case (cfg[i].mode)
        lec_pkg::LEC_NORMAL: begin
          // Carry in may enter the table as a plain signal
          f = cfg[i].lut[idx4];
          // Carry passes so the chain keeps running
          cout = carry[i];
          comb = f;
        end
        lec_pkg::LEC_ARITH: begin
          // Low half gives the sum, high half the carry
          f = cfg[i].lut[{1'b0, idx3}];
          cout = cfg[i].lut[{1'b1, idx3}];
          comb = f;
        end
        lec_pkg::LEC_UPDN: begin
          // Tables see carry, direction and the fed back value
          f = cfg[i].lut[{1'b0, carry[i], d[1], q}];
          cout = cfg[i].lut[{1'b1, carry[i], d[1], q}];
          // Load wins, then enable, else hold
          cnt_mux = d[3] ? d[0] : (d[2] ? f : q);
          comb = cnt_mux;
          ff_eff = lec_pkg::LEC_FF_D;
        end
        lec_pkg::LEC_CLRCNT: begin
          // Second input now the synchronous clear, low active
          f = cfg[i].lut[{1'b0, carry[i], d[2], q}];
          cout = cfg[i].lut[{1'b1, carry[i], d[2], q}];
          cnt_mux = d[3] ? d[0] : (d[2] ? f : q);
          comb = cnt_mux & d[1];
          ff_eff = lec_pkg::LEC_FF_D;
        end
      endcase
      // Cascade joins table results of normal and arithmetic cells
      if (cfg[i].mode == lec_pkg::LEC_NORMAL ||
          cfg[i].mode == lec_pkg::LEC_ARITH) begin
        if (cfg[i].casc_en) begin
          // OR is built by inverting both sides of an AND
          comb = cfg[i].casc_or ? ~(~f & ~casc[i]) : f & casc[i];
        end
        // Each joined normal cell widens the function by four inputs, an arithmetic cell by three
        cso = comb;
      end
      v = comb;
    end

    // Storage element with clock choice and clear/preset
    lec_cell_reg u_reg (
      .mclk(mclk),
      .rstn(rstn),
      .ff(ff_eff),
      .amode(cfg[i].amode),
      .v(v),
      .aux(d[3]),
      .ld_data(d[3]),
      .tick(tick[cfg[i].clk_sel]),
      .ctl_a_n(line[`LEC_CTL_A]),
      .ctl_b_n(line[`LEC_CTL_B]),
      .q(q)
    );

    // Bypass shows the combined result, else the stored value
    assign out_c[i] = cfg[i].bypass ? comb : q;
    // Links to the next cell
    assign carry[i + 1] = cout;
    assign casc[i + 1] = cso;
  end

  // Outputs registered towards the fabric and row
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cell_output <= '0;
      carry_out <= 1'b0;
      cascade_out <= 1'b0;
    end else begin
      cell_output <= out_c;
      carry_out <= carry[CELLS];
      // Last cell feeds the first cell of the next cluster
      cascade_out <= casc[CELLS];
    end
  end

endmodule // lec_cluster

// File: hw/lec_map.svh
// Register offsets, field positions and reset values of the cell cluster
`ifndef LEC_MAP_SVH
`define LEC_MAP_SVH

// Byte offsets: cell i config word sits at base plus four times i
`define LEC_CFG_BASE 8'h00
`define LEC_CTRL_OFS 8'h20
`define LEC_STAT_OFS 8'h24

// Reset values
`define LEC_CFG_RST 32'h0000_0000
`define LEC_CTRL_RST 16'hFB73

// Control line field: 4 bits per line, source low, pin index high
`define LEC_LINE_W 4
`define LEC_SRC_LSB 0
`define LEC_PIN_LSB 2

// Status word fields
`define LEC_STAT_COUT_BIT 8
`define LEC_STAT_CASC_BIT 9

// Control line numbers: two clocks, two clear or preset lines
`define LEC_CLK0 0
`define LEC_CLK1 1
`define LEC_CTL_A 2
`define LEC_CTL_B 3

`endif

// File: hw/lec_pkg.sv
// Types shared by the cell cluster and its storage cell
package lec_pkg;

  // Operating mode, Gray coded
  typedef enum logic [1:0] {
    LEC_NORMAL = 2'h0,
    LEC_ARITH  = 2'h1,
    LEC_UPDN   = 2'h3,
    LEC_CLRCNT = 2'h2
  } lec_mode_e;

  // Storage element behaviour
  typedef enum logic [1:0] {
    LEC_FF_D  = 2'h0,
    LEC_FF_T  = 2'h1,
    LEC_FF_JK = 2'h3,
    LEC_FF_SR = 2'h2
  } lec_ff_e;

  // Clear and preset arrangement; code 7 is illegal
  typedef enum logic [2:0] {
    LEC_AS_NONE    = 3'h0,
    LEC_AS_CLR     = 3'h1,
    LEC_AS_PRE     = 3'h2,
    LEC_AS_CLR_PRE = 3'h3,
    LEC_AS_LD_CLR  = 3'h4,
    LEC_AS_LD_PRE  = 3'h5,
    LEC_AS_LD      = 3'h6
  } lec_amode_e;

  // Source of a cluster control line
  typedef enum logic [1:0] {
    LEC_SRC_DED   = 2'h0,
    LEC_SRC_IO    = 2'h1,
    LEC_SRC_LOCAL = 2'h2,
    LEC_SRC_HIGH  = 2'h3
  } lec_src_e;

  // One cell configuration word
  typedef struct packed {
    logic [3:0] spare;
    lec_amode_e amode;
    logic clk_sel;
    logic casc_or;
    logic casc_en;
    logic carry_sel;
    logic bypass;
    lec_ff_e ff;
    lec_mode_e mode;
    logic [15:0] lut;
  } lec_cell_cfg_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lec_bus_s;

endpackage

// File: testbench/lec_cluster_assertions.sv
// Port checker for the cell cluster
`timescale 1ns/1ps

module lec_cluster_assertions #(
  parameter int CELLS = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire lec_pkg::lec_bus_s bus,
  input wire logic [31:0] rdata,
  // Fabric and row side
  input wire logic [3:0] local_ctl,
  input wire logic [CELLS-1:0][3:0] data_in,
  input wire logic carry_in,
  input wire logic carry_out,
  input wire logic cascade_out,
  input wire logic [CELLS-1:0] cell_output
);
  logic [31:0] cfg0; // Shadow of cell 0 config word
  logic [15:0] ctrl; // Shadow of control line word
  logic [11:0] m0; // Mode bits of cell 0
  assign m0 = cfg0[27:16];
  // Follow writes so properties know how cell 0 is set up
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg0 <= 32'h0;
      ctrl <= 16'hFB73;
    end else if (bus.wr) begin
      if (bus.addr == 8'h00) cfg0 <= bus.wdata;
      if (bus.addr == 8'h20) ctrl <= bus.wdata[15:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_lut_comb;
    m0 == 12'h010 |=> cell_output[0] == $past(cfg0[data_in[0]]);
  endproperty
  a_lut_comb: assert property (p_lut_comb) else $error("table out");
  property p_carry_sel;
    m0 == 12'h030 |=>
      cell_output[0] == $past(cfg0[{carry_in, data_in[0][2:0]}]);
  endproperty
  a_carry_sel: assert property (p_carry_sel) else $error("carry sel");
  property p_arith;
    m0 == 12'h011 |=>
      cell_output[0] == $past(cfg0[{1'b0, carry_in, data_in[0][1:0]}]);
  endproperty
  a_arith: assert property (p_arith) else $error("arith sum");
  property p_tick;
    m0 == 12'h200 && ctrl[15:12] == 4'hE && ctrl[1:0] == 2'h2 &&
      local_ctl[3] && $rose(local_ctl[0]) |=>
      ##1 cell_output[0] == $past(cfg0[data_in[0]], 2);
  endproperty
  a_tick: assert property (p_tick) else $error("stored value");
  property p_hold;
    m0 == 12'h200 && ctrl[1:0] == 2'h2 && local_ctl[3] &&
      !$rose(local_ctl[0]) |=> ##1 $stable(cell_output[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_clear;
    cfg0[27:25] == 3'h1 && !cfg0[20] && ctrl[15:12] == 4'hE &&
      !local_ctl[3] |=> ##1 !cell_output[0];
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_status;
    bus.rd && bus.addr == 8'h24 |=> rdata == {22'h0, $past(cascade_out),
      $past(carry_out), $past(cell_output[7:0])};
  endproperty
  a_status: assert property (p_status) else $error("status");
  property p_cfg_back;
    bus.wr && bus.addr == 8'h00 ##2 bus.rd && bus.addr == 8'h00 |=>
      rdata == $past(bus.wdata, 3);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("cfg word");
endmodule // lec_cluster_assertions

bind lec_cluster lec_cluster_assertions #(.CELLS(CELLS))
  i_lec_cluster_assertions (.mclk(mclk), .rstn(rstn), .bus(bus),
  .rdata(rdata), .local_ctl(local_ctl), .data_in(data_in),
  .carry_in(carry_in), .carry_out(carry_out),
  .cascade_out(cascade_out), .cell_output(cell_output));

// File: testbench/lec_cluster_tb.sv
// Self-checking bench for the cell cluster
`timescale 1ns/1ps

module lec_cluster_tb;
  logic mclk;
  logic rstn;
  lec_pkg::lec_bus_s bus;
  logic [31:0] rdata;
  logic [3:0] ded_in;
  logic [3:0] io_ctl_in;
  logic [3:0] local_ctl;
  logic [7:0][3:0] data_in;
  logic carry_in, cascade_in, carry_out, cascade_out;
  logic [7:0] cell_output;
  logic nb_carry, nb_casc; // Left neighbour chain values
  int errors, cmp_count, k;
  logic [8:0] sum; // Expected add result
  logic [15:0] lut; // Table for lookup sweep
  // Storage rows: config, data per tick, output after each tick
  logic [31:0] ff_cfg [6] = '{32'h0200FFFF, 32'h0204FFFF, 32'h020CFFFF,
    32'h0208FFFF, 32'h0203FFFF, 32'h0202FFFF};
  logic [7:0] ff_dat [6] = '{8'h00, 8'h00, 8'h88, 8'h88, 8'h98, 8'h64};
  logic [1:0] ff_exp [6] = '{2'b11, 2'b10, 2'b10, 2'b11, 2'b10, 2'b10};
  // Cascade rows: config, cell 5 data, {cascade in, expected}
  logic [31:0] cs_cfg [5] = '{32'h00508000, 32'h00508000, 32'h00508000,
    32'h00D00000, 32'h00D00000};
  logic [3:0] cs_d5 [5] = '{4'hF, 4'hE, 4'hF, 4'h0, 4'h0};
  logic [1:0] cs_ce [5] = '{2'b11, 2'b10, 2'b00, 2'b11, 2'b00};
  // Add rows: {carry, a, b}
  logic [16:0] ar [3] = '{{1'b0, 8'hFF, 8'h01}, {1'b1, 8'h5A, 8'hA5},
    {1'b0, 8'h12, 8'h34}};

  lec_cluster #(.CELLS(8)) i_lec_cluster (.mclk(mclk), .rstn(rstn),
    .bus(bus), .rdata(rdata), .ded_in(ded_in), .io_ctl_in(io_ctl_in),
    .local_ctl(local_ctl), .data_in(data_in), .carry_in(carry_in),
    .cascade_in(cascade_in), .carry_out(carry_out),
    .cascade_out(cascade_out), .cell_output(cell_output));
  lec_row_model i_lec_row_model (.mclk(mclk), .rstn(rstn),
    .nb_carry(nb_carry), .nb_casc(nb_casc), .carry_in(carry_in),
    .cascade_in(cascade_in));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One-cycle write; the idle cycle after keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask

  // Pulse clock line 0 on every source; pins need two extra edges
  task automatic tick;
    @(posedge mclk);
    {ded_in[0], io_ctl_in[0], local_ctl[0]} <= 3'b111;
    @(posedge mclk);
    {ded_in[0], io_ctl_in[0], local_ctl[0]} <= 3'b000;
    cyc(6);
  endtask

  // Low active clear on line B from local routing
  task automatic clr;
    @(posedge mclk);
    local_ctl[3] <= 1'b0;
    repeat (2) @(posedge mclk);
    local_ctl[3] <= 1'b1;
    cyc(3);
  endtask

  task automatic results;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results;
  end

  initial begin
    rstn = 1'b0;
    bus = '0;
    ded_in = 4'h0;
    io_ctl_in = 4'h0;
    local_ctl = 4'hC; // Load and clear lines idle high
    data_in = '0;
    nb_carry = 1'b0;
    nb_casc = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    // Reset values, last cell, unmapped space
    rd(8'h20, 32'h0000FB73);
    rd(8'h1C, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h24, 32'h0);
    wr(8'h00, 32'hA5A5A5A5);
    rd(8'h00, 32'hA5A5A5A5);
    // Table sweep, then carry replacing the fourth input
    lut = 16'h6A3C;
    wr(8'h00, {16'h0010, lut});
    for (int i = 0; i < 32; i++) begin
      if (i == 16) wr(8'h00, {16'h0030, lut});
      @(posedge mclk);
      data_in[0] <= (i < 16) ? i[3:0] : {~i[3], i[2:0]};
      nb_carry <= i[3];
      cyc(3);
      chk(cell_output[0], lut[i[3:0]]);
    end
    // Eight-bit ripple add across the row of cells
    for (int c = 0; c < 8; c++) wr(8'(4 * c), 32'h0011E896);
    for (int r = 0; r < 3; r++) begin
      sum = ar[r][15:8] + ar[r][7:0] + ar[r][16];
      @(posedge mclk);
      for (int c = 0; c < 8; c++) data_in[c] <= {2'b0, ar[r][c], ar[r][8+c]};
      nb_carry <= ar[r][16];
      cyc(4);
      chk(cell_output, sum[7:0]);
      chk(carry_out, sum[8]);
    end
    // Wide AND and OR joined along the cascade
    for (int r = 0; r < 5; r++) begin
      for (int c = 0; c < 8; c++) wr(8'(4 * c), cs_cfg[r]);
      @(posedge mclk);
      for (int c = 0; c < 8; c++)
        data_in[c] <= (c == 5) ? cs_d5[r] : (cs_cfg[r][23] ? 4'h0 : 4'hF);
      nb_casc <= cs_ce[r][1];
      cyc(4);
      chk(cascade_out, cs_ce[r][0]);
      chk(cell_output[7], cs_ce[r][0]);
    end
    // Storage kinds and counters; last rows clock from pins
    wr(8'h20, 32'h0000EB72);
    for (int s = 0; s < 8; s++) begin
      k = (s < 6) ? s : 0;
      if (s >= 6) wr(8'h20, 32'h0000EB70 | 32'(s - 6));
      wr(8'h00, ff_cfg[k]);
      @(posedge mclk);
      data_in[0] <= ff_dat[k][7:4];
      clr;
      chk(cell_output[0], 1'b0);
      tick;
      chk(cell_output[0], ff_exp[k][1]);
      @(posedge mclk);
      data_in[0] <= ff_dat[k][3:0];
      tick;
      chk(cell_output[0], ff_exp[k][0]);
    end
    // Load of the fourth input through line A, one then zero
    wr(8'h20, 32'h0000EA72);
    wr(8'h00, 32'h0C000000);
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk);
      data_in[0] <= (j == 0) ? 4'h8 : 4'h0;
      local_ctl[2] <= 1'b0;
      @(posedge mclk);
      local_ctl[2] <= 1'b1;
      cyc(3);
      chk(cell_output[0], 32'(j == 0));
    end
    results;
  end
endmodule // lec_cluster_tb

// File: testbench/lec_row_model.sv
// Left neighbour cluster feeding the row chains into the block
`timescale 1ns/1ps

module lec_row_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Values the neighbour's last cell produces
  input wire logic nb_carry,
  input wire logic nb_casc,
  // Row chains towards the block
  output logic carry_in,
  output logic cascade_in
);
  // Neighbour registers its chain outputs, one cycle late like a cluster
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      carry_in <= 1'b0;
      cascade_in <= 1'b0;
    end else begin
      carry_in <= nb_carry;
      cascade_in <= nb_casc;
    end
  end
endmodule // lec_row_model
